// ### rtl/ebfps_map.vh
`ifndef EBFPS_MAP_VH
`define EBFPS_MAP_VH

// Register byte offsets
`define EBF_OFS_IOF      8'h00
`define EBF_OFS_PBC      8'h04
`define EBF_OFS_XBC      8'h08
`define EBF_OFS_CMD      8'h0C
`define EBF_OFS_WDAT     8'h10
`define EBF_OFS_RDAT     8'h14
`define EBF_OFS_STAT     8'h18

// Flag control field positions
`define EBF_IOF_DIR0     1
`define EBF_IOF_OUT0     2
`define EBF_IOF_IN0      3
`define EBF_IOF_DIR1     5
`define EBF_IOF_OUT1     6
`define EBF_IOF_IN1      7

// Command register fields
`define EBF_CMD_WR       24
`define EBF_CMD_XB       25
`define EBF_CMD_KIND_LO  26
`define EBF_CMD_KIND_HI  27

// Access kinds
`define EBF_KIND_PLAIN   2'h0
`define EBF_KIND_LOAD    2'h1
`define EBF_KIND_STORE   2'h2
`define EBF_KIND_SIGNAL  2'h3

// Reset values
`define EBF_WAIT_RST     3'h7
`define EBF_IOF_RST      2'h0

// Phase clock timing
`define EBF_CLK_NS       10
`define EBF_H_PERIOD_NS  40
`define EBF_H_STEPS      (`EBF_H_PERIOD_NS / `EBF_CLK_NS)

`endif

// ### rtl/ebfps_top.v
// How it works
// - Strobe toggles only on phase one falling
// - Strobe stays low across back-to-back reads
// - New address presented after phase one falling
// - Back-to-back writes change address on rising
// - Ready sampled on phase one rising edges
// - Write data driven from fall past rise
// - Interlocked load: flag zero low, sample flag one
// - Interlocked store drives flag zero high first
// - Store address waits while pipeline stalled
// - Signal op: flag zero low then high
// - Output bit drives pin after phase three
// - Direction bit enables driver after phase three
// - Input mode releases pin, captures input bit
// - Reset asynchronous; sequence may start cycle late
// - Reset acts asynchronously on flag/peripheral pins
// - Pins high impedance while reset held
// - Reset loads seven wait states both buses
// - Hold request asynchronous, not granted while reset held
`timescale 1ns/10ps
`default_nettype none
`include "ebfps_map.vh"

module ebfps_top (
	input  wire        CLK_I,             // System clock
	input  wire        NRST_I,            // Async reset, active low
	input  wire        PSEL_I,            // APB select
	input  wire        PENABLE_I,         // APB enable
	input  wire        PWRITE_I,          // APB direction
	input  wire [7:0]  PADDR_I,           // APB byte address
	input  wire [31:0] PWDATA_I,          // APB write data
	output reg  [31:0] PRDATA_O,          // APB read data
	output reg         PREADY_O,          // APB ready
	output reg         PSLVERR_O,         // APB error
	output reg         PHASE_CLK_ONE_O,   // Phase clock one
	output reg         PHASE_CLK_THREE_O, // Phase clock three
	output reg  [23:0] ADDR_O,            // External address
	output reg         ADDR_OE_N_O,       // Address/control enable, low drives
	output reg         EXT_STROBE_N_O,    // Access strobe, active low
	output reg         RW_O,              // High read, low write
	output reg  [31:0] DATA_O,            // Write data
	output reg         DATA_OE_N_O,       // Data enable, low drives
	input  wire [31:0] DATA_I,            // Read data
	input  wire        READY_I,           // External ready, high ends access
	input  wire        HOLD_N_I,          // Bus hold request, active low
	output reg         HOLD_ACK_N_O,      // Bus hold granted, active low
	input  wire        EXEC_STALL_I,      // Pipeline conflict, same clock
	input  wire        FLAG_PIN_ZERO_I,   // Flag pin zero level
	output reg         FLAG_PIN_ZERO_O,   // Flag pin zero drive value
	output reg         FLAG_PIN_ZERO_OE_N_O, // Flag zero enable, low drives
	input  wire        FLAG_PIN_ONE_I,    // Flag pin one level
	output reg         FLAG_PIN_ONE_O,    // Flag pin one drive value
	output reg         FLAG_PIN_ONE_OE_N_O, // Flag one enable, low drives
	output reg         PERIPH_PIN_HIZ_O   // Serial/timer pins forced off
);

	localparam ST_IDLE = 2'd0;
	localparam ST_ACC  = 2'd1;
	localparam ST_SIGH = 2'd2;
	localparam integer PH_LAST_I = `EBF_H_STEPS - 1;
	localparam [1:0] PH_LAST = PH_LAST_I[1:0];

	////////////////////////////////////////////////////////////////////////
	// Reset release and phase clocks
	reg  [1:0]  rst_sr;
	reg  [1:0]  ph;
	wire        run = rst_sr[1];
	wire        h1r = run & (ph == PH_LAST);
	wire        h1f = run & (ph == 2'd0);
	wire        h3r = run & (ph == 2'd1);

	// Release may land one clock late depending on input timing
	always @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rst_sr            <= 2'd0;
			ph                <= 2'd0;
			PHASE_CLK_ONE_O   <= 1'b0;
			PHASE_CLK_THREE_O <= 1'b0;
			PERIPH_PIN_HIZ_O  <= 1'b1;
		end else begin
			rst_sr            <= {rst_sr[0], 1'b1};
			PERIPH_PIN_HIZ_O  <= ~run;
			if (run) begin
				ph <= ph + 2'd1;
			end
			PHASE_CLK_ONE_O   <= h1r;
			PHASE_CLK_THREE_O <= h3r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: ready, hold, flag zero, flag one
	reg  [3:0]  s1;
	reg  [3:0]  s2;
	reg  [3:0]  s3;
	reg  [3:0]  stab;
	wire [3:0]  agree = ~(s2 ^ s3);
	wire        rdy_st  = stab[0];
	wire        hold_st = stab[1];

	always @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			s1   <= 4'h0;
			s2   <= 4'h0;
			s3   <= 4'h0;
			stab <= 4'h0;
		end else begin
			s1   <= {FLAG_PIN_ONE_I, FLAG_PIN_ZERO_I, ~HOLD_N_I, READY_I};
			s2   <= s1;
			s3   <= s2;
			stab <= (stab & ~agree) | (s2 & agree);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and APB slave
	reg  [1:0]  iof_dir;
	reg  [1:0]  iof_out;
	reg  [1:0]  iof_in;
	reg  [1:0]  sh_dir;
	reg  [1:0]  sh_out;
	reg         iof_set;
	reg  [2:0]  pbc_wait;
	reg  [2:0]  xbc_wait;
	reg  [31:0] wdat;
	reg  [31:0] rdata;
	reg         pend_v;
	reg         pend_mark;
	reg  [27:0] pend_cmd;
	reg  [31:0] pend_wd;
	reg  [1:0]  st;
	reg         done;
	reg         cur_wr;
	reg  [1:0]  cur_kind;
	reg  [2:0]  wcnt;
	reg  [31:0] rd_mux;
	reg         bad_adr;

	wire        apb_acc = PSEL_I & PENABLE_I;
	wire        apb_set = apb_acc & ~PREADY_O;
	wire        wr_ok   = apb_acc & PREADY_O & PWRITE_I & ~PSLVERR_O;
	wire [1:0]  pend_kind = pend_cmd[`EBF_CMD_KIND_HI:`EBF_CMD_KIND_LO];
	wire        pend_wr   = pend_cmd[`EBF_CMD_WR];

	always @* begin
		rd_mux  = 32'h0000_0000;
		bad_adr = 1'b0;
		case (PADDR_I)
			`EBF_OFS_IOF: begin
				rd_mux[`EBF_IOF_DIR0] = iof_dir[0];
				rd_mux[`EBF_IOF_OUT0] = iof_out[0];
				rd_mux[`EBF_IOF_IN0]  = iof_in[0];
				rd_mux[`EBF_IOF_DIR1] = iof_dir[1];
				rd_mux[`EBF_IOF_OUT1] = iof_out[1];
				rd_mux[`EBF_IOF_IN1]  = iof_in[1];
			end
			`EBF_OFS_PBC:  rd_mux[2:0] = pbc_wait;
			`EBF_OFS_XBC:  rd_mux[2:0] = xbc_wait;
			`EBF_OFS_CMD:  rd_mux[27:0] = pend_cmd;
			`EBF_OFS_WDAT: rd_mux = wdat;
			`EBF_OFS_RDAT: rd_mux = rdata;
			`EBF_OFS_STAT: rd_mux[4:0] = {done, rdy_st, ~HOLD_ACK_N_O, pend_v, st != ST_IDLE};
			default:       bad_adr = 1'b1;
		endcase
	end

	// One wait state: answer registered so read data comes from a flop
	always @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
			pbc_wait  <= `EBF_WAIT_RST;
			xbc_wait  <= `EBF_WAIT_RST;
			wdat      <= 32'h0000_0000;
			sh_dir    <= `EBF_IOF_RST;
			sh_out    <= `EBF_IOF_RST;
		end else begin
			PREADY_O  <= apb_set;
			PSLVERR_O <= apb_set & (bad_adr | (PWRITE_I & pend_v & (PADDR_I == `EBF_OFS_CMD)));
			if (apb_set & ~PWRITE_I) begin
				PRDATA_O <= rd_mux;
			end
			if (wr_ok) begin
				case (PADDR_I)
					`EBF_OFS_IOF: begin
						sh_dir <= {PWDATA_I[`EBF_IOF_DIR1], PWDATA_I[`EBF_IOF_DIR0]};
						sh_out <= {PWDATA_I[`EBF_IOF_OUT1], PWDATA_I[`EBF_IOF_OUT0]};
					end
					`EBF_OFS_PBC:  pbc_wait <= PWDATA_I[2:0];
					`EBF_OFS_XBC:  xbc_wait <= PWDATA_I[2:0];
					`EBF_OFS_WDAT: wdat <= PWDATA_I;
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flag pins: changes land on phase three rising
	reg  [1:0]  next_dir;
	reg  [1:0]  next_out;
	wire        ilk_first = pend_v & ~pend_mark & (pend_kind != `EBF_KIND_PLAIN);
	wire        ilk_lo = ilk_first & (pend_kind != `EBF_KIND_STORE);
	wire        ilk_hi = (ilk_first & (pend_kind == `EBF_KIND_STORE)) | (st == ST_SIGH);
	wire        sig_go = h1f & (st == ST_IDLE) & pend_v & pend_mark & HOLD_ACK_N_O &
	                     (pend_kind == `EBF_KIND_SIGNAL);

	always @* begin
		next_dir = iof_set ? sh_dir : iof_dir;
		next_out = iof_set ? sh_out : iof_out;
		if (ilk_lo) begin
			next_dir[0] = 1'b1;
			next_out[0] = 1'b0;
		end
		if (ilk_hi) begin
			next_dir[0] = 1'b1;
			next_out[0] = 1'b1;
		end
	end

	always @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			iof_dir              <= `EBF_IOF_RST;
			iof_out              <= `EBF_IOF_RST;
			iof_in               <= `EBF_IOF_RST;
			iof_set              <= 1'b0;
			FLAG_PIN_ZERO_O      <= 1'b0;
			FLAG_PIN_ONE_O       <= 1'b0;
			FLAG_PIN_ZERO_OE_N_O <= 1'b1;
			FLAG_PIN_ONE_OE_N_O  <= 1'b1;
		end else begin
			if (wr_ok & (PADDR_I == `EBF_OFS_IOF)) begin
				iof_set <= 1'b1;
			end else if (h3r) begin
				iof_set <= 1'b0;
			end
			if (h3r) begin
				iof_dir              <= next_dir;
				iof_out              <= next_out;
				FLAG_PIN_ZERO_O      <= next_out[0];
				FLAG_PIN_ONE_O       <= next_out[1];
				FLAG_PIN_ZERO_OE_N_O <= ~next_dir[0];
				FLAG_PIN_ONE_OE_N_O  <= ~next_dir[1];
			end
			if (h1f) begin
				if (!iof_dir[0]) begin
					iof_in[0] <= stab[2];
				end
				// Interlocked loads and signal ops read flag one even when it is an output
				if (!iof_dir[1] || sig_go || (st == ST_ACC && cur_kind == `EBF_KIND_LOAD)) begin
					iof_in[1] <= stab[3];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// External bus sequencer
	wire        can_issue = pend_v & HOLD_ACK_N_O & (pend_kind != `EBF_KIND_SIGNAL) &
	                        ((pend_kind == `EBF_KIND_PLAIN) | pend_mark) &
	                        ~((pend_kind == `EBF_KIND_STORE) & EXEC_STALL_I);
	wire        acc_end = (st == ST_ACC) & done;
	wire        chain_rd = acc_end & ~cur_wr & can_issue & ~pend_wr;
	wire        go = h1f & can_issue & ((st == ST_IDLE) | chain_rd);

	always @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			st             <= ST_IDLE;
			done           <= 1'b0;
			cur_wr         <= 1'b0;
			cur_kind       <= `EBF_KIND_PLAIN;
			wcnt           <= 3'h0;
			pend_v         <= 1'b0;
			pend_mark      <= 1'b0;
			pend_cmd       <= 28'h000_0000;
			pend_wd        <= 32'h0000_0000;
			rdata          <= 32'h0000_0000;
			ADDR_O         <= 24'h00_0000;
			ADDR_OE_N_O    <= 1'b1;
			EXT_STROBE_N_O <= 1'b1;
			RW_O           <= 1'b1;
			DATA_O         <= 32'h0000_0000;
			DATA_OE_N_O    <= 1'b1;
			HOLD_ACK_N_O   <= 1'b1;
		end else begin
			if (wr_ok & (PADDR_I == `EBF_OFS_CMD)) begin
				pend_v    <= 1'b1;
				pend_mark <= 1'b0;
				pend_cmd  <= PWDATA_I[27:0];
				pend_wd   <= wdat;
			end else if (h3r & ilk_first) begin
				pend_mark <= 1'b1;
			end
			if (h1r & (st == ST_ACC) & ~done) begin
				if (wcnt != 3'h0) begin
					wcnt <= wcnt - 3'h1;
				end else if (rdy_st) begin
					done <= 1'b1;
					// Next write's address moves on the rising edge
					if (cur_wr & can_issue & pend_wr) begin
						ADDR_O <= pend_cmd[23:0];
					end
				end
			end
			if (h1f & acc_end & ~cur_wr) begin
				rdata <= DATA_I;
			end
			if (h3r & (st == ST_SIGH)) begin
				st <= ST_IDLE;
			end
			if (sig_go) begin
				st     <= ST_SIGH;
				pend_v <= 1'b0;
			end else if (go) begin
				st             <= ST_ACC;
				done           <= 1'b0;
				cur_wr         <= pend_wr;
				cur_kind       <= pend_kind;
				wcnt           <= pend_cmd[`EBF_CMD_XB] ? xbc_wait : pbc_wait;
				pend_v         <= 1'b0;
				ADDR_O         <= pend_cmd[23:0];
				EXT_STROBE_N_O <= 1'b0;
				RW_O           <= ~pend_wr;
				DATA_O         <= pend_wd;
				DATA_OE_N_O    <= ~pend_wr;
			end else if (h1f & acc_end) begin
				st             <= ST_IDLE;
				EXT_STROBE_N_O <= 1'b1;
				DATA_OE_N_O    <= 1'b1;
				RW_O           <= 1'b1;
			end
			// Grant only between accesses so a strobe is never cut short
			if (h1f & (st == ST_IDLE) & ~go & ~sig_go) begin
				HOLD_ACK_N_O <= ~hold_st;
				ADDR_OE_N_O  <= hold_st;
			end else if (h1f & go) begin
				ADDR_OE_N_O <= 1'b0;
			end
		end
	end

endmodule // ebfps_top
`default_nettype wire

// ### verification/ebfps_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ebfps_sva (
	input wire logic        CLK_I,                // Clock
	input wire logic        NRST_I,               // Reset, active low
	input wire logic        PWRITE_I,             // APB direction
	input wire logic [7:0]  PADDR_I,              // APB address
	input wire logic [31:0] PRDATA_O,             // APB read data
	input wire logic        PREADY_O,             // APB ready
	input wire logic        PHASE_CLK_ONE_O,      // Phase one
	input wire logic        PHASE_CLK_THREE_O,    // Phase three
	input wire logic [23:0] ADDR_O,               // Address
	input wire logic        ADDR_OE_N_O,          // Address enable
	input wire logic        EXT_STROBE_N_O,       // Strobe
	input wire logic        DATA_OE_N_O,          // Data enable
	input wire logic        FLAG_PIN_ZERO_O,      // Flag zero value
	input wire logic        FLAG_PIN_ZERO_OE_N_O, // Flag zero enable
	input wire logic        FLAG_PIN_ONE_O,       // Flag one value
	input wire logic        FLAG_PIN_ONE_OE_N_O,  // Flag one enable
	input wire logic        PERIPH_PIN_HIZ_O      // Peripheral float
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	a_strobe_on_fall: assert property ($changed(EXT_STROBE_N_O) |-> $fell(PHASE_CLK_ONE_O))
		else $error("strobe moved off phase one fall");
	a_addr_on_edge: assert property ($changed(ADDR_O) |-> $fell(PHASE_CLK_ONE_O) || $rose(PHASE_CLK_ONE_O))
		else $error("address moved off phase one edge");
	a_wdata_start: assert property ($fell(DATA_OE_N_O) |-> $fell(PHASE_CLK_ONE_O) && !EXT_STROBE_N_O)
		else $error("write data started off phase one fall");
	a_wdata_hold: assert property ($rose(DATA_OE_N_O) |-> $fell(PHASE_CLK_ONE_O))
		else $error("write data released early");
	a_phase_order: assert property ($rose(PHASE_CLK_ONE_O) |-> ##2 PHASE_CLK_THREE_O ##2 PHASE_CLK_ONE_O)
		else $error("phase clocks out of order");
	a_flag0_three: assert property ($changed({FLAG_PIN_ZERO_O, FLAG_PIN_ZERO_OE_N_O}) |-> $rose(PHASE_CLK_THREE_O))
		else $error("flag zero moved off phase three rise");
	a_flag1_three: assert property ($changed({FLAG_PIN_ONE_O, FLAG_PIN_ONE_OE_N_O}) |-> $rose(PHASE_CLK_THREE_O))
		else $error("flag one moved off phase three rise");
	// Second reset edge: the first one loads the reset values
	a_reset_float: assert property (disable iff (1'b0) !NRST_I ##1 !NRST_I |->
		FLAG_PIN_ZERO_OE_N_O && FLAG_PIN_ONE_OE_N_O && PERIPH_PIN_HIZ_O && ADDR_OE_N_O)
		else $error("pins driven during reset");
	a_spare_zero: assert property (PREADY_O && !PWRITE_I && PADDR_I == 8'h00 |->
		PRDATA_O[31:8] == 24'h00_0000 && PRDATA_O[4] == 1'b0 && PRDATA_O[0] == 1'b0)
		else $error("spare flag bits not zero");
endmodule // ebfps_sva
bind ebfps_top ebfps_sva chk_u (.CLK_I, .NRST_I, .PWRITE_I, .PADDR_I, .PRDATA_O, .PREADY_O,
	.PHASE_CLK_ONE_O, .PHASE_CLK_THREE_O, .ADDR_O, .ADDR_OE_N_O, .EXT_STROBE_N_O, .DATA_OE_N_O,
	.FLAG_PIN_ZERO_O, .FLAG_PIN_ZERO_OE_N_O, .FLAG_PIN_ONE_O, .FLAG_PIN_ONE_OE_N_O, .PERIPH_PIN_HIZ_O);
`default_nettype wire

// ### verification/ebfps_mem.sv
`timescale 1ns/10ps
`default_nettype none
module ebfps_mem (
	input  wire logic        clk_i,      // Clock
	input  wire logic        strobe_n_i, // Strobe
	input  wire logic        rw_i,       // High read
	input  wire logic [23:0] addr_i,     // Address
	input  wire logic [31:0] wdata_i,    // Write data
	output logic      [31:0] rdata_o,    // Read data
	output logic             ready_o     // Done
);
	logic [31:0] last = 32'h0000_0000;
	logic [23:0] wr_addr = 24'h00_0000;
	logic [31:0] wr_data = 32'h0000_0000;
	// Unselected bus shows inverse of last word, never a stale match
	assign rdata_o = (!strobe_n_i && rw_i) ? {addr_i[15:0], ~addr_i[15:0]} : ~last;
	assign ready_o = !strobe_n_i;
	always @(posedge clk_i) begin
		if (!strobe_n_i && rw_i)
			last <= rdata_o;
		if (!strobe_n_i && !rw_i) begin
			wr_addr <= addr_i;
			wr_data <= wdata_i;
		end
	end
endmodule // ebfps_mem
`default_nettype wire

// ### verification/ext_bus_flag_pin_sequencing_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "ebfps_map.vh"
module ext_bus_flag_pin_sequencing_bench;
	logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, stall = 0, ext0 = 0, ext1 = 0, rdy, rerr;
	logic [7:0] padr = 8'h00;
	logic [31:0] pwd = 32'h0000_0000, prd, din, dout, rdat;
	logic pready, pslverr, p1, p3, stb_n, rw, doe_n, f0o, f0oe_n, f1o, f1oe_n, f0, f1;
	logic [23:0] adr;
	int num_errors = 0, tests_run = 0;
	assign f0 = (f0oe_n === 1'b0) ? f0o : ext0;
	assign f1 = (f1oe_n === 1'b0) ? f1o : ext1;
	ebfps_top dut_u (.CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.PHASE_CLK_ONE_O(p1), .PHASE_CLK_THREE_O(p3), .ADDR_O(adr), .ADDR_OE_N_O(), .EXT_STROBE_N_O(stb_n),
		.RW_O(rw), .DATA_O(dout), .DATA_OE_N_O(doe_n), .DATA_I(din), .READY_I(rdy), .HOLD_N_I(1'b1),
		.HOLD_ACK_N_O(), .EXEC_STALL_I(stall), .FLAG_PIN_ZERO_I(f0), .FLAG_PIN_ZERO_O(f0o),
		.FLAG_PIN_ZERO_OE_N_O(f0oe_n), .FLAG_PIN_ONE_I(f1), .FLAG_PIN_ONE_O(f1o),
		.FLAG_PIN_ONE_OE_N_O(f1oe_n), .PERIPH_PIN_HIZ_O());
	ebfps_mem mem_u (.clk_i(clk), .strobe_n_i(stb_n), .rw_i(rw), .addr_i(adr), .wdata_i(dout),
		.rdata_o(din), .ready_o(rdy));
	initial begin
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1; pen <= 0; pwr <= w; padr <= a; pwd <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (pready !== 1'b1 && n++ < 50);
		if (pready !== 1'b1) begin
			num_errors++;
			$display("ERROR apb ready expected 1 seen %b", pready);
		end
		rdat = prd;
		rerr = pslverr;
		psel <= 0; pen <= 0;
	endtask
	task automatic idle();
		int n;
		n = 0;
		do apb(0, `EBF_OFS_STAT, 0); while (rdat[1:0] !== 2'h0 && n++ < 100);
		chk("idle", rdat[1:0], 2'h0);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#200000 num_errors++;
		final_report();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1;
		apb(0, `EBF_OFS_IOF, 0); chk("iof rst", rdat, 32'h0000_0000);
		apb(0, `EBF_OFS_PBC, 0); chk("pbc rst", rdat[2:0], `EBF_WAIT_RST);
		apb(0, `EBF_OFS_XBC, 0); chk("xbc rst", rdat[2:0], `EBF_WAIT_RST);
		apb(0, 8'h1C, 0); chk("unmapped err", {31'h0, rerr}, 32'h0000_0001);
		chk("unmapped", rdat, 32'h0000_0000);
		apb(1, `EBF_OFS_IOF, 32'hFFFF_FF66);
		repeat (8) @(posedge clk);
		apb(0, `EBF_OFS_IOF, 0); chk("iof rd", rdat & 32'hFFFF_FF77, 32'h0000_0066);
		chk("flag out", {f0o, f0oe_n, f1o, f1oe_n}, 4'hA);
		apb(1, `EBF_OFS_IOF, 32'h0000_0000);
		ext0 <= 1;
		repeat (16) @(posedge clk);
		apb(0, `EBF_OFS_IOF, 0); chk("flag in", rdat, 32'h0000_0008);
		chk("flag off", {f0oe_n, f1oe_n}, 2'h3);
		apb(1, `EBF_OFS_PBC, 0);
		apb(1, `EBF_OFS_WDAT, 32'h1234_5678);
		apb(1, `EBF_OFS_CMD, 32'h0100_0040); idle();
		chk("wr addr", {8'h00, mem_u.wr_addr}, 32'h0000_0040);
		chk("wr data", mem_u.wr_data, 32'h1234_5678);
		apb(1, `EBF_OFS_CMD, 32'h0000_0055); idle();
		apb(0, `EBF_OFS_RDAT, 0); chk("rd", rdat, 32'h0055_FFAA);
		ext1 <= 1;
		apb(1, `EBF_OFS_CMD, 32'h0400_0010); idle();
		apb(0, `EBF_OFS_RDAT, 0); chk("load rd", rdat, 32'h0010_FFEF);
		chk("load f0", {f0o, f0oe_n}, 2'h0);
		apb(0, `EBF_OFS_IOF, 0); chk("load f1", rdat[7], 1'b1);
		stall <= 1;
		apb(1, `EBF_OFS_WDAT, 32'hA5A5_0F0F);
		apb(1, `EBF_OFS_CMD, 32'h0900_0020);
		repeat (20) @(posedge clk);
		chk("stall", {stb_n, f0o, f0oe_n}, 3'h6);
		stall <= 0;
		idle();
		chk("store addr", {8'h00, mem_u.wr_addr}, 32'h0000_0020);
		chk("store data", mem_u.wr_data, 32'hA5A5_0F0F);
		apb(1, `EBF_OFS_IOF, 32'h0000_0000);
		apb(1, `EBF_OFS_CMD, 32'h0C00_0030); idle();
		repeat (8) @(posedge clk);
		chk("signal", {f0o, f0oe_n}, 2'h2);
		final_report();
	end
endmodule // ext_bus_flag_pin_sequencing_bench
`default_nettype wire
